// File: acsc_assertions.sv
// port checker for the clock-status and control block
`timescale 1ns/100ps
`default_nettype none
module acsc_assertions
(
	// watched ports
	input wire logic        REF_CLK,
	input wire logic        RESET,
	input wire logic        SCL,
	input wire logic        SDA_O,
	input wire logic        SDA_OE_N,
	input wire logic        SHUTDOWN,
	input wire logic        DC_BLOCK_EN,
	input wire logic [1:0]  DEEMPH_SEL,
	input wire logic [9:0]  UNMUTE_LEVEL,
	input wire logic [23:0] AUDIO_DATA,
	input wire logic        AUDIO_VALID,
	input wire logic        AUDIO_READY
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	// open-drain pin: only ever pulls low
	a_sda_low: assert property (SDA_O == 1'b0)
		else $error("sda drive value high");
	// sda may only change while scl is low
	a_ack_scl_low: assert property ($fell(SDA_OE_N) |-> !SCL)
		else $error("sda pulled low during scl high");
	a_release_scl_low: assert property ($rose(SDA_OE_N) |-> !SCL)
		else $error("sda released during scl high");
	a_dc_reset_on: assert property ($fell(RESET) |-> DC_BLOCK_EN)
		else $error("dc block off after reset");
	a_deemph_reset: assert property ($fell(RESET) |-> DEEMPH_SEL == 2'h0)
		else $error("de-emphasis not off after reset");
	a_unmute_cap: assert property (UNMUTE_LEVEL <= 10'h200)
		else $error("unmute level beyond ramp end");
	a_unmute_step: assert property (UNMUTE_LEVEL > $past(UNMUTE_LEVEL) |->
		UNMUTE_LEVEL == $past(UNMUTE_LEVEL) + 10'h1 || UNMUTE_LEVEL == 10'h200)
		else $error("unmute rose by an illegal step");
	a_shutdown_mute: assert property (SHUTDOWN ##1 SHUTDOWN |-> UNMUTE_LEVEL == 10'h0)
		else $error("level not muted in shutdown");
	a_valid_hold: assert property (AUDIO_VALID && !AUDIO_READY |=>
		AUDIO_VALID && $stable(AUDIO_DATA))
		else $error("audio word dropped or changed while stalled");
endmodule
bind acsc_top acsc_assertions u_chk
(
	.REF_CLK, .RESET, .SCL, .SDA_O, .SDA_OE_N, .SHUTDOWN, .DC_BLOCK_EN,
	.DEEMPH_SEL, .UNMUTE_LEVEL, .AUDIO_DATA, .AUDIO_VALID, .AUDIO_READY
);
`default_nettype wire

// File: acsc_audio_src.sv
// serial audio source model: master, bit and frame clocks and i2s words
`timescale 1ns/100ps
`default_nettype none
module acsc_audio_src
(
	// control from the bench
	input  wire logic        run,
	input  wire logic        slow,
	input  wire logic        arm,
	input  wire logic [23:0] word,
	// audio pins
	output var logic         mclk,
	output var logic         sclk,
	output var logic         lrclk,
	output var logic         sdin
);
	logic [24:0] q [$];
	logic [23:0] w;
	logic        pend;
	int          i;
	initial
	begin
		{mclk, sclk, lrclk, sdin, pend} = 5'h0;
		w = 24'h0;
		i = 0;
		forever
		begin
			#24;
			// idle: clocks stand still, data never keeps a stale level
			if (!run)
				sdin = ~sdin;
			else
			begin
				// master-clock ratio 64, or 32 when slow, in the 48k band only
				sclk = 1'b1;
				mclk = slow ? ~mclk : 1'b1;
				#24;
				sclk = 1'b0;
				mclk = slow ? mclk : 1'b0;
				if (i == 0)
				begin
					if (pend)
						q.push_back({lrclk, w});
					lrclk = ~lrclk;
					w = arm ? word : 24'h0;
					pend = arm;
				end
				// msb one bit clock after the frame edge
				sdin = (i >= 1 && i <= 24) ? w[24 - i] : ~sdin;
				i = (i + 1) % 32;
			end
		end
	end
endmodule
`default_nettype wire

// File: acsc_pkg.sv
// types shared by the clock-status and control block
package acsc_pkg;
	typedef logic [7:0] acsc_byte_t;
	typedef enum logic [2:0]
	{
		I2C_IDLE = 3'b000,
		I2C_RXB  = 3'b001,
		I2C_ACK  = 3'b011,
		I2C_TXB  = 3'b010,
		I2C_RACK = 3'b110
	} acsc_i2c_e;
	typedef enum logic [1:0]
	{
		JUST_RIGHT = 2'h0,
		JUST_I2S   = 2'h1,
		JUST_LEFT  = 2'h2,
		JUST_NONE  = 2'h3
	} acsc_just_e;
endpackage

// File: acsc_regs.svh
// register offsets, reset values, field positions and timing counts
`ifndef ACSC_REGS_SVH
`define ACSC_REGS_SVH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define ACSC_OFS_CLK_STATUS 8'h00
`define ACSC_OFS_FW_ID      8'h01
`define ACSC_OFS_ERR_FLAGS  8'h02
`define ACSC_OFS_SYS_CTRL1  8'h03
`define ACSC_OFS_SER_FMT    8'h04

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define ACSC_RST_SYS_CTRL1  8'h80
`define ACSC_RST_SER_FMT    4'h5
`define ACSC_RST_RATE       3'h3
`define ACSC_RST_RATIO      3'h3
`define ACSC_RST_ERR        8'h00

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define ACSC_ERR_MCLK       7
`define ACSC_ERR_PLL        6
`define ACSC_ERR_SCLK       5
`define ACSC_ERR_LRCLK      4
`define ACSC_ERR_SLIP       3
`define ACSC_ERR_CLIP       2
`define ACSC_ERR_PROT       1
`define ACSC_CTL_DCBLOCK    7
`define ACSC_CTL_HARD       5

// --------------------------------------------------------------------
// sample-rate and ratio codes, detection thresholds
// --------------------------------------------------------------------
`define ACSC_RATE_32K       3'h0
`define ACSC_RATE_48K       3'h3
`define ACSC_RATE_16K       3'h4
`define ACSC_RATE_24K       3'h5
`define ACSC_RATE_8K        3'h6
`define ACSC_RATE_12K       3'h7
`define ACSC_THR_48K        16'h1518
`define ACSC_THR_32K        16'h1c84
`define ACSC_THR_24K        16'h2a30
`define ACSC_THR_16K        16'h38a4
`define ACSC_THR_12K        16'h53fc
`define ACSC_THR_R128       10'h060
`define ACSC_THR_R192       10'h0a0
`define ACSC_THR_R256       10'h0e0
`define ACSC_THR_R384       10'h140
`define ACSC_THR_R512       10'h1c0
`define ACSC_TOL_MCLK       10'h002
`define ACSC_TOL_SCLK       8'h02
`define ACSC_TOL_LR         16'h0010

// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define ACSC_REF_CLK_MHZ    200
`define ACSC_LR_TIMEOUT_US  200
`define ACSC_RAMP_STEPS     10'h200
`define ACSC_FRAMES_PER_STEP 3'h4
`define ACSC_STABLE_FRAMES  3'h4

`endif

// File: acsc_top.sv
// audio clock detection, error flags, control registers and serial input
// --------------------------------------------------------------------
// Functional notes
// - sample-rate code in status bits 7:5, reserved codes never reported
// - master-clock ratio code in status bits 4:2, reserved never reported
// - rates detected automatically, visible only as read-only status
// - identification register returns a fixed 8-bit firmware code
// - error flags are sticky; only a written zero clears them
// - bit 7 set when master-clock cycles per frame change
// - bit 5 set when bit-clock cycles per frame change
// - bit 4 set when frame-clock frequency changes
// - bit 3 set when frame clock drifts from internal frame sync
// - bit 6 lock fail, bit 2 clip, bit 1 protection, bit 0 zero
// - control bit 7 enables dc-blocking filter, default on
// - control bit 5 picks soft ramp or hard unmute after clock error
// - control bits 1:0 select de-emphasis, default none
// - format register low nibble decodes justification and word length
// - format resets to I2S 24-bit, code 0101
// - control bit 5 also picks unmute style leaving shutdown
// - soft unmute ramp has 512 steps
// --------------------------------------------------------------------
`include "acsc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module acsc_fifo
#(
	parameter int WIDTH = 25,
	parameter int DEPTH = 16
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp;
	logic [AW:0]      rp;
	logic             empty;
	logic             take;

	assign empty    = (wp == rp);
	assign in_ready = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
	assign take     = (!out_valid || out_ready) && !empty;

	always_ff @(posedge clk)
	begin
		if (in_valid && in_ready)
			mem[wp[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			wp <= '0;
		else if (in_valid && in_ready)
			wp <= wp + 1'b1;
	end

	// output stage is a register so the drain side sees flop outputs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rp        <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end
		else if (!out_valid || out_ready)
		begin
			out_valid <= !empty;
			out_data  <= mem[rp[AW-1:0]];
			if (take)
				rp <= rp + 1'b1;
		end
	end
endmodule

module acsc_top
	import acsc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a,
	parameter acsc_byte_t FW_ID = 8'h5a, // arbitrary value
	parameter int LR_TIMEOUT_CYC = `ACSC_LR_TIMEOUT_US * `ACSC_REF_CLK_MHZ
)
(
	// system
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	// control port
	input  wire logic        SCL,
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE_N,
	// serial audio pins
	input  wire logic        MCLK,
	input  wire logic        SCLK,
	input  wire logic        LRCLK,
	input  wire logic        SDIN,
	// fault sources and shutdown
	input  wire logic        PLL_LOCK_FAIL,
	input  wire logic        CLIP_DETECT,
	input  wire logic        PROTECT_FAULT,
	input  wire logic        SHUTDOWN,
	// processing controls
	output logic             DC_BLOCK_EN,
	output logic [1:0]       DEEMPH_SEL,
	output logic [9:0]       UNMUTE_LEVEL,
	// audio word stream
	output logic [23:0]      AUDIO_DATA,
	output logic             AUDIO_RIGHT,
	output logic             AUDIO_VALID,
	input  wire logic        AUDIO_READY
);
	localparam int P_SCL = 0;
	localparam int P_SDA = 1;
	localparam int P_MCK = 2;
	localparam int P_SCK = 3;
	localparam int P_LR  = 4;
	localparam int P_SD  = 5;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pin_raw;
	logic [5:0] s1;
	logic [5:0] s2;
	logic [5:0] s3;
	assign pin_raw = {SDIN, LRCLK, SCLK, MCLK, SDA_I, SCL};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_sync
			always_ff @(posedge REF_CLK)
			begin
				s1[gi] <= pin_raw[gi];
				s2[gi] <= s1[gi];
				s3[gi] <= s2[gi];
			end
		end
	endgenerate

	logic mck_rise;
	logic sck_rise;
	logic lr_rise;
	logic lr_edge;
	assign mck_rise = s2[P_MCK] & ~s3[P_MCK];
	assign sck_rise = s2[P_SCK] & ~s3[P_SCK];
	assign lr_rise  = s2[P_LR] & ~s3[P_LR];
	assign lr_edge  = s2[P_LR] ^ s3[P_LR];

	// ----------------------------------------------------------------
	// frame measurement and clock error detection
	// ----------------------------------------------------------------
	logic [15:0] ref_cnt;
	logic [9:0]  mck_cnt;
	logic [7:0]  sck_cnt;
	logic [15:0] meas_ref;
	logic [9:0]  meas_mck;
	logic [7:0]  meas_sck;
	logic [9:0]  fs_pos;
	logic [1:0]  frames;
	logic [2:0]  rate_code;
	logic [2:0]  ratio_code;
	logic        ev_mck;
	logic        ev_sck;
	logic        ev_lr;
	logic        ev_slip;
	logic        timeout;
	logic        have_prev;

	assign have_prev = frames[1];
	assign timeout   = (32'(ref_cnt) == LR_TIMEOUT_CYC);

	always_ff @(posedge REF_CLK)
	begin
		if (RESET || lr_rise)
		begin
			ref_cnt <= '0;
			mck_cnt <= '0;
			sck_cnt <= '0;
		end
		else
		begin
			if (ref_cnt != 16'hffff)
				ref_cnt <= ref_cnt + 16'h0001;
			if (mck_rise && mck_cnt != 10'h3ff)
				mck_cnt <= mck_cnt + 10'h001;
			if (sck_rise && sck_cnt != 8'hff)
				sck_cnt <= sck_cnt + 8'h01;
		end
	end

	// internal frame sync counts master clock at the learned length, restarting on each frame-clock rise
	always_ff @(posedge REF_CLK)
	begin
		if (RESET || lr_rise)
			fs_pos <= '0;
		else if (mck_rise)
			fs_pos <= (fs_pos + 10'h001 >= meas_mck) ? 10'h000
				: fs_pos + 10'h001;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RESET || timeout)
			frames <= '0;
		else if (lr_rise && !have_prev)
			frames <= frames + 2'h1;
	end

	always_ff @(posedge REF_CLK)
	begin
		ev_mck  <= 1'b0;
		ev_sck  <= 1'b0;
		ev_lr   <= timeout;
		ev_slip <= 1'b0;
		if (RESET)
		begin
			meas_ref <= '0;
			meas_mck <= '0;
			meas_sck <= '0;
			ev_lr    <= 1'b0;
		end
		else if (lr_rise)
		begin
			meas_ref <= ref_cnt;
			meas_mck <= mck_cnt;
			meas_sck <= sck_cnt;
			if (have_prev)
			begin
				ev_mck <= (mck_cnt > meas_mck + `ACSC_TOL_MCLK)
					|| (meas_mck > mck_cnt + `ACSC_TOL_MCLK);
				ev_sck <= (sck_cnt > meas_sck + `ACSC_TOL_SCLK)
					|| (meas_sck > sck_cnt + `ACSC_TOL_SCLK);
				ev_lr  <= (ref_cnt > meas_ref + `ACSC_TOL_LR)
					|| (meas_ref > ref_cnt + `ACSC_TOL_LR);
				ev_slip <= (fs_pos > `ACSC_TOL_MCLK)
					&& (fs_pos + `ACSC_TOL_MCLK < meas_mck);
			end
		end
	end

	// status follows detection only; no register write reaches it
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			rate_code  <= `ACSC_RST_RATE;
			ratio_code <= `ACSC_RST_RATIO;
		end
		else if (lr_rise && have_prev)
		begin
			if (ref_cnt < `ACSC_THR_48K)
				rate_code <= `ACSC_RATE_48K;
			else if (ref_cnt < `ACSC_THR_32K)
				rate_code <= `ACSC_RATE_32K;
			else if (ref_cnt < `ACSC_THR_24K)
				rate_code <= `ACSC_RATE_24K;
			else if (ref_cnt < `ACSC_THR_16K)
				rate_code <= `ACSC_RATE_16K;
			else if (ref_cnt < `ACSC_THR_12K)
				rate_code <= `ACSC_RATE_12K;
			else
				rate_code <= `ACSC_RATE_8K;
			if (mck_cnt < `ACSC_THR_R128)
				ratio_code <= 3'h0;
			else if (mck_cnt < `ACSC_THR_R192)
				ratio_code <= 3'h1;
			else if (mck_cnt < `ACSC_THR_R256)
				ratio_code <= 3'h2;
			else if (mck_cnt < `ACSC_THR_R384)
				ratio_code <= 3'h3;
			else if (mck_cnt < `ACSC_THR_R512)
				ratio_code <= 3'h4;
			else
				ratio_code <= 3'h5;
		end
	end

	// ----------------------------------------------------------------
	// control port (byte-wide slave, auto-incrementing pointer)
	// ----------------------------------------------------------------
	acsc_i2c_e  i2c_st;
	acsc_byte_t sh_in;
	acsc_byte_t sh_out;
	acsc_byte_t ptr;
	logic [3:0] bitc;
	logic [1:0] byte_n;
	logic       rw;
	logic       nack;
	logic       wr_stb;
	acsc_byte_t wr_ofs;
	acsc_byte_t wr_byte;
	acsc_byte_t err_flags;
	acsc_byte_t sys_ctrl;
	logic [3:0] ser_fmt;
	logic       scl_rise;
	logic       scl_fall;
	logic       i2c_start;
	logic       i2c_stop;

	assign scl_rise  = s2[P_SCL] & ~s3[P_SCL];
	assign scl_fall  = ~s2[P_SCL] & s3[P_SCL];
	assign i2c_start = s2[P_SCL] & s3[P_SCL] & ~s2[P_SDA] & s3[P_SDA];
	assign i2c_stop  = s2[P_SCL] & s3[P_SCL] & s2[P_SDA] & ~s3[P_SDA];

	acsc_byte_t rd_now;

	function automatic acsc_byte_t reg_read(input acsc_byte_t a);
		unique case (a)
			`ACSC_OFS_CLK_STATUS: reg_read = {rate_code, ratio_code, 2'b00};
			`ACSC_OFS_FW_ID:      reg_read = FW_ID;
			`ACSC_OFS_ERR_FLAGS:  reg_read = err_flags;
			`ACSC_OFS_SYS_CTRL1:  reg_read = sys_ctrl;
			`ACSC_OFS_SER_FMT:    reg_read = {4'h0, ser_fmt};
			default:              reg_read = 8'h00;
		endcase
	endfunction

	// byte the pointer selects; its top bit goes straight onto the line
	always_comb
	begin
		rd_now = reg_read(ptr);
	end

	always_ff @(posedge REF_CLK)
	begin
		wr_stb <= 1'b0;
		if (RESET || i2c_stop)
		begin
			i2c_st   <= I2C_IDLE;
			SDA_OE_N <= 1'b1;
			bitc     <= '0;
			byte_n   <= '0;
			rw       <= 1'b0;
			nack     <= 1'b0;
			if (RESET)
				ptr <= '0;
		end
		else if (i2c_start)
		begin
			i2c_st   <= I2C_RXB;
			SDA_OE_N <= 1'b1;
			bitc     <= '0;
			byte_n   <= '0;
		end
		else
		begin
			unique case (i2c_st)
				I2C_IDLE: ;
				I2C_RXB:
					if (scl_rise)
					begin
						sh_in <= {sh_in[6:0], s2[P_SDA]};
						bitc  <= bitc + 4'h1;
					end
					else if (scl_fall && bitc == 4'h8)
					begin
						bitc <= '0;
						if (byte_n == 2'h0)
						begin
							rw <= sh_in[0];
							i2c_st <= (sh_in[7:1] == DEV_ADDR) ? I2C_ACK : I2C_IDLE;
							SDA_OE_N <= (sh_in[7:1] != DEV_ADDR);
						end
						else
						begin
							i2c_st   <= I2C_ACK;
							SDA_OE_N <= 1'b0;
							if (byte_n == 2'h1)
								ptr <= sh_in;
							else
							begin
								wr_stb  <= 1'b1;
								wr_ofs  <= ptr;
								wr_byte <= sh_in;
								ptr     <= ptr + 8'h01;
							end
						end
						if (byte_n != 2'h2)
							byte_n <= byte_n + 2'h1;
					end
				I2C_ACK:
					if (scl_fall)
					begin
						if (rw)
						begin
							i2c_st   <= I2C_TXB;
							sh_out   <= rd_now;
							SDA_OE_N <= rd_now[7];
							ptr      <= ptr + 8'h01;
						end
						else
						begin
							i2c_st   <= I2C_RXB;
							SDA_OE_N <= 1'b1;
						end
					end
				I2C_TXB:
					if (scl_fall)
					begin
						bitc <= bitc + 4'h1;
						if (bitc == 4'h7)
						begin
							bitc     <= '0;
							i2c_st   <= I2C_RACK;
							SDA_OE_N <= 1'b1;
						end
						else
						begin
							sh_out   <= {sh_out[6:0], 1'b0};
							SDA_OE_N <= sh_out[6];
						end
					end
				I2C_RACK:
					if (scl_rise)
						nack <= s2[P_SDA];
					else if (scl_fall)
					begin
						i2c_st   <= nack ? I2C_IDLE : I2C_TXB;
						sh_out   <= rd_now;
						SDA_OE_N <= nack | rd_now[7];
						if (!nack)
							ptr <= ptr + 8'h01;
					end
				default:
					i2c_st <= I2C_IDLE;
			endcase
		end
	end

	// open-drain line only ever pulled low
	always_ff @(posedge REF_CLK)
	begin
		SDA_O <= 1'b0;
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	acsc_byte_t err_set;
	assign err_set = {ev_mck, PLL_LOCK_FAIL, ev_sck, ev_lr | timeout,
		ev_slip, CLIP_DETECT, PROTECT_FAULT, 1'b0};

	// a new event in the clearing cycle stays set
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
			err_flags <= `ACSC_RST_ERR;
		else if (wr_stb && wr_ofs == `ACSC_OFS_ERR_FLAGS)
			err_flags <= (err_flags & wr_byte) | err_set;
		else
			err_flags <= err_flags | err_set;
	end

	// offsets 0 and 1 take no write
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			sys_ctrl <= `ACSC_RST_SYS_CTRL1;
			ser_fmt  <= `ACSC_RST_SER_FMT;
		end
		else if (wr_stb)
		begin
			if (wr_ofs == `ACSC_OFS_SYS_CTRL1)
				sys_ctrl <= wr_byte & 8'ha3;
			if (wr_ofs == `ACSC_OFS_SER_FMT)
				ser_fmt <= wr_byte[3:0];
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		DC_BLOCK_EN <= RESET ? 1'b1 : sys_ctrl[`ACSC_CTL_DCBLOCK];
		DEEMPH_SEL  <= RESET ? 2'b00 : sys_ctrl[1:0];
	end

	// ----------------------------------------------------------------
	// mute after clock error or shutdown, then soft or hard unmute
	// ----------------------------------------------------------------
	logic       clk_bad;
	logic [2:0] good_frames;
	logic [2:0] step_div;
	logic       any_clk_ev;
	assign any_clk_ev = ev_mck | ev_sck | ev_lr | ev_slip | timeout;

	always_ff @(posedge REF_CLK)
	begin
		if (RESET || any_clk_ev || !have_prev)
		begin
			clk_bad     <= 1'b1;
			good_frames <= '0;
		end
		else if (lr_rise && clk_bad)
		begin
			good_frames <= good_frames + 3'h1;
			if (good_frames + 3'h1 == `ACSC_STABLE_FRAMES)
				clk_bad <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RESET || clk_bad || SHUTDOWN)
		begin
			UNMUTE_LEVEL <= '0;
			step_div     <= '0;
		end
		else if (sys_ctrl[`ACSC_CTL_HARD])
			UNMUTE_LEVEL <= `ACSC_RAMP_STEPS;
		else if (lr_rise && UNMUTE_LEVEL != `ACSC_RAMP_STEPS)
		begin
			step_div <= step_div + 3'h1;
			if (step_div + 3'h1 == `ACSC_FRAMES_PER_STEP)
			begin
				step_div     <= '0;
				UNMUTE_LEVEL <= UNMUTE_LEVEL + 10'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// serial audio receiver
	// ----------------------------------------------------------------
	acsc_just_e just;
	logic [7:0] wl;
	logic [7:0] start;
	logic [7:0] idx;
	logic [23:0] sh_aud;
	logic [24:0] push_data;
	logic        push_valid;
	logic        push_ready;
	logic [24:0] q;

	always_comb
	begin
		just = JUST_NONE;
		wl   = 8'd24;
		if (ser_fmt < 4'h9)
		begin
			just = (ser_fmt < 4'h3) ? JUST_RIGHT
				: (ser_fmt < 4'h6) ? JUST_I2S : JUST_LEFT;
			unique case (ser_fmt % 4'h3)
				4'h0:    wl = 8'd16;
				4'h1:    wl = 8'd20;
				default: wl = 8'd24;
			endcase
		end
		start = (just == JUST_I2S) ? 8'h01
			: (just == JUST_RIGHT) ? {1'b0, meas_sck[7:1]} - wl : 8'h00;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RESET || lr_edge)
		begin
			idx    <= '0;
			sh_aud <= '0;
		end
		else if (sck_rise)
		begin
			if (idx != 8'hff)
				idx <= idx + 8'h01;
			if (idx >= start && idx < start + wl)
				sh_aud <= {sh_aud[22:0], s2[P_SD]};
		end
	end

	// a word still waiting when the next arrives is overwritten
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			push_valid <= 1'b0;
			push_data  <= '0;
		end
		else if (lr_edge && have_prev && just != JUST_NONE)
		begin
			push_valid <= 1'b1;
			push_data[24] <= (just == JUST_I2S) ? s3[P_LR] : ~s3[P_LR];
			push_data[23:0] <= sh_aud << (8'd24 - wl);
		end
		else if (push_ready)
			push_valid <= 1'b0;
	end

	acsc_fifo #(.WIDTH(25), .DEPTH(16)) u_fifo
	(
		.clk       (REF_CLK),
		.rst       (RESET),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (AUDIO_VALID),
		.out_ready (AUDIO_READY),
		.out_data  (q)
	);
	assign AUDIO_DATA  = q[23:0];
	assign AUDIO_RIGHT = q[24];
endmodule

`default_nettype wire

// File: tb_acsc_top.sv
// self-checking bench for the clock-status and control block
`timescale 1ns/100ps
`default_nettype none
module tb_acsc_top;
	localparam int FRAME = 615;
	logic        ref_clk, reset, scl, m_sda, shutdown, pll_fail, clip, prot;
	logic        audio_ready, stall, run, slow, arm, mclk, sclk, lrclk, sdin;
	logic        sda_o, sda_oe_n, dc_block_en, audio_right, audio_valid;
	logic [1:0]  deemph_sel;
	logic [9:0]  unmute_level;
	logic [23:0] audio_data;
	logic [31:0] seed;
	logic [7:0]  v;
	logic [7:0]  rst_val [5] = '{8'h6c, 8'h5a, 8'h00, 8'h80, 8'h05};
	int          mismatches, compares;
	wire logic   sda;
	// pull-up wire: low if either party pulls
	assign sda = m_sda & (sda_oe_n | sda_o);
	// idle-link timeout must land after the error-flag reset-value read
	acsc_top #(.LR_TIMEOUT_CYC(5000)) uut
	(
		.REF_CLK(ref_clk), .RESET(reset), .SCL(scl), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .MCLK(mclk), .SCLK(sclk),
		.LRCLK(lrclk), .SDIN(sdin), .PLL_LOCK_FAIL(pll_fail),
		.CLIP_DETECT(clip), .PROTECT_FAULT(prot), .SHUTDOWN(shutdown),
		.DC_BLOCK_EN(dc_block_en), .DEEMPH_SEL(deemph_sel),
		.UNMUTE_LEVEL(unmute_level), .AUDIO_DATA(audio_data),
		.AUDIO_RIGHT(audio_right), .AUDIO_VALID(audio_valid),
		.AUDIO_READY(audio_ready)
	);
	acsc_audio_src src
	(
		.run(run), .slow(slow), .arm(arm), .word(seed[23:0]),
		.mclk(mclk), .sclk(sclk), .lrclk(lrclk), .sdin(sdin)
	);
	// ----
	// helpers
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic results();
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wclk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic bit1(input logic d, output logic r);
		m_sda = d;
		wclk(10);
		scl = 1'b1;
		wclk(10);
		r = sda;
		scl = 1'b0;
		wclk(10);
	endtask
	task automatic start();
		m_sda = 1'b1;
		wclk(10);
		scl = 1'b1;
		wclk(10);
		m_sda = 1'b0;
		wclk(10);
		scl = 1'b0;
		wclk(10);
	endtask
	task automatic stop();
		m_sda = 1'b0;
		wclk(10);
		scl = 1'b1;
		wclk(10);
		m_sda = 1'b1;
		wclk(10);
	endtask
	task automatic xbyte(input logic [7:0] d, input logic chk,
		output logic [7:0] r);
		logic b;
		for (int k = 7; k >= 0; k--)
		begin
			bit1(d[k], b);
			r[k] = b;
		end
		bit1(1'b1, b);
		if (chk)
			check(32'(b), 32'h0);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		start();
		xbyte(8'h54, 1'b1, r);
		xbyte(a, 1'b1, r);
		xbyte(d, 1'b1, r);
		stop();
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		logic [7:0] r;
		start();
		xbyte(8'h54, 1'b1, r);
		xbyte(a, 1'b1, r);
		start();
		xbyte(8'h55, 1'b1, r);
		xbyte(8'hff, 1'b0, r);
		stop();
		check(32'(r & m), 32'(e));
	endtask
	// ----
	// clock, random stream, watchdog, scoreboard
	// ----
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		#1;
		seed = lfsr(seed);
		audio_ready = !stall && (seed[2] || seed[5]);
	end
	initial
	begin
		wclk(90000);
		mismatches++;
		results();
	end
	always @(posedge ref_clk)
		if (audio_valid === 1'b1 && audio_ready === 1'b1)
		begin
			if (src.q.size() > 0)
				check(32'({audio_right, audio_data}), 32'(src.q.pop_front()));
			else
				check(32'(audio_data), 32'h0);
		end
	// ----
	// main sequence
	// ----
	initial
	begin
		seed = 32'h0001602a;
		{reset, scl, m_sda} = 3'b111;
		{shutdown, pll_fail, clip, prot, stall, run, slow, arm} = 8'h0;
		audio_ready = 1'b0;
		mismatches = 0;
		compares = 0;
		wclk(6);
		reset = 1'b0;
		wclk(4);
		for (int k = 0; k < 5; k++)
			reg_rd(8'(k), rst_val[k], 8'hff);
		reg_wr(8'h00, 8'hff);
		reg_wr(8'h01, 8'h00);
		reg_rd(8'h00, 8'h6c, 8'hff);
		reg_rd(8'h01, 8'h5a, 8'hff);
		for (int k = 0; k < 4; k++)
		begin
			v = {seed[7:2], 2'(k)};
			reg_wr(8'h03, v);
			reg_rd(8'h03, v & 8'ha3, 8'hff);
			check(32'(dc_block_en), 32'(v[7]));
			check(32'(deemph_sel), 32'(k));
		end
		reg_wr(8'h04, 8'hf9);
		reg_rd(8'h04, 8'h09, 8'hff);
		reg_wr(8'h04, 8'h05);
		// drop the flag left by the idle-link timeout
		reg_wr(8'h02, 8'h00);
		pll_fail = 1'b1;
		wclk(1);
		{pll_fail, clip} = 2'b01;
		wclk(1);
		{clip, prot} = 2'b01;
		wclk(1);
		prot = 1'b0;
		reg_rd(8'h02, 8'h46, 8'hff);
		reg_wr(8'h02, 8'hfb);
		reg_rd(8'h02, 8'h42, 8'hff);
		reg_wr(8'h02, 8'h00);
		reg_rd(8'h02, 8'h00, 8'hff);
		// hard unmute, then live audio
		reg_wr(8'h03, 8'ha0);
		run = 1'b1;
		wclk(8 * FRAME);
		reg_wr(8'h02, 8'h00);
		wclk(4 * FRAME);
		reg_rd(8'h02, 8'h00, 8'hff);
		reg_rd(8'h00, 8'h60, 8'hff);
		check(32'(unmute_level), 32'h200);
		arm = 1'b1;
		wclk(4 * FRAME);
		// sink stalls long enough to nearly fill the buffer
		stall = 1'b1;
		wclk(7 * FRAME);
		stall = 1'b0;
		wclk(4 * FRAME);
		arm = 1'b0;
		wclk(2 * FRAME);
		reg_wr(8'h03, 8'h80);
		shutdown = 1'b1;
		wclk(4);
		check(32'(unmute_level), 32'h0);
		shutdown = 1'b0;
		wclk(12 * FRAME);
		check(32'(unmute_level > 10'h0 && unmute_level < 10'h4), 32'h1);
		slow = 1'b1;
		wclk(2 * FRAME);
		check(32'(unmute_level), 32'h0);
		reg_rd(8'h02, 8'h80, 8'h80);
		slow = 1'b0;
		run = 1'b0;
		wclk(4600);
		reg_rd(8'h02, 8'h10, 8'h10);
		results();
	end
endmodule
`default_nettype wire
